// ### hw/hotplug_seq_consts.vh
// Constants for the dual-slot hot-plug power sequencer
`ifndef HOTPLUG_SEQ_CONSTS_VH
`define HOTPLUG_SEQ_CONSTS_VH
`define CLK_MHZ 100
`define POR_TIME_US 500
`define POR_CYCLES (`POR_TIME_US * `CLK_MHZ)
`define FLT_TIME_US 20
`define FLT_CYCLES (`FLT_TIME_US * `CLK_MHZ)
`define RAMP_TIME_US 1
`define RAMP_CYCLES (`RAMP_TIME_US * `CLK_MHZ)
`define OFS_CTRL_A 8'h08
`define OFS_CTRL_B 8'h0c
`define OFS_STAT_A 8'h10
`define OFS_STAT_B 8'h14
`define OFS_COMMON 8'h18
`define CTL_MAIN 0
`define CTL_AUX 1
`define ST_MAINF 0
`define ST_AUXF 1
`define ST_UVF 2
`define ST_STATE 4
`define ST_AUXON 6
`define CM_MASK 0
`define CM_BUSCTL 1
`define CM_FLT 2
`define CM_STBY 8
`define CM_PEND 9
`define SLOT_OFF 2'b00
`define SLOT_RAMP 2'b01
`define SLOT_ON 2'b10
`define SLOT_TRIP 2'b11
`endif

// ### hw/hotplug_power_sequencer.v
// Dual-slot hot-plug power sequencer with AHB-Lite register slave
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`include "hotplug_seq_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module hotplug_power_sequencer #(
	parameter POR_CYCLES = `POR_CYCLES,
	parameter FLT_CYCLES_A = `FLT_CYCLES,
	parameter FLT_CYCLES_B = `FLT_CYCLES
) (
	input wire clk_sys,
	input wire rstn,
	input wire standbySupplyOk,
	input wire [3:0] mainSupplyOk,
	input wire [1:0] mainEnablePin,
	input wire [1:0] slotAuxEnablePin,
	input wire [1:0] mainOverCurrent,
	input wire [1:0] mainFastTrip,
	input wire [1:0] auxOverCurrent,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg [31:0] hrdata,
	output reg hresp,
	output reg [1:0] mainGateOn,
	output reg [1:0] mainDischarge,
	output reg [1:0] slotAuxOutput,
	output reg [1:0] auxDischarge,
	output reg [1:0] slotFaultN,
	output reg irqN,
	output reg standbyMode,
	output reg porActive
);

	// Fault timer limit per slot
	function [15:0] fltLim;
		input integer s;
		begin
			if (s == 0) fltLim = FLT_CYCLES_A[15:0];
			else fltLim = FLT_CYCLES_B[15:0];
		end
	endfunction

	// Overcurrent duration counter step
	function [15:0] fltStep;
		input oc;
		input [15:0] cnt;
		begin
			if (!oc) fltStep = 16'h0000;
			else if (cnt == 16'hffff) fltStep = cnt;
			else fltStep = cnt + 16'h0001;
		end
	endfunction

	// Two-stage synchronisers for all supply, enable and fault sense pins
	reg [14:0] syncA_q;
	reg [14:0] syncB_q;
	wire stbyOk = syncB_q[14];
	wire [3:0] supOk = syncB_q[13:10];
	wire [1:0] pinMain = syncB_q[9:8];
	wire [1:0] pinAux = syncB_q[7:6];
	wire [1:0] ocMain = syncB_q[5:4];
	wire [1:0] fastTrip = syncB_q[3:2];
	wire [1:0] ocAux = syncB_q[1:0];

	reg [31:0] porCnt_q, porCnt_d;
	reg porDone_q, porDone_d;
	reg [3:0] ctrl_q, ctrl_d;
	reg intMask_q, intMask_d;
	reg busCtl_q, busCtl_d;
	reg [5:0] stat_q, stat_d;
	reg [3:0] slotSt_q, slotSt_d;
	reg [15:0] rampCnt_q [0:1];
	reg [15:0] rampCnt_d [0:1];
	reg [15:0] mFlt_q [0:1];
	reg [15:0] mFlt_d [0:1];
	reg [15:0] aFlt_q [0:1];
	reg [15:0] aFlt_d [0:1];
	reg [1:0] auxOn_q, auxOn_d;
	reg [1:0] auxTrip_q, auxTrip_d;
	reg [1:0] faultPin_q, faultPin_d;
	reg pend_q, pend_d;
	reg pendWr_q, pendWr_d;
	reg [7:0] pendAddr_q, pendAddr_d;
	reg hreadyout_d;
	reg [31:0] hrdata_d;
	reg [1:0] gate_d;
	reg irqN_d;
	reg uv;
	reg mEn;
	reg aEn;
	reg [31:0] rd;
	integer i;

	always @* begin
		porCnt_d = porCnt_q;
		porDone_d = porDone_q;
		ctrl_d = ctrl_q;
		intMask_d = intMask_q;
		busCtl_d = busCtl_q;
		stat_d = stat_q;
		slotSt_d = slotSt_q;
		rampCnt_d[0] = rampCnt_q[0];
		rampCnt_d[1] = rampCnt_q[1];
		mFlt_d[0] = mFlt_q[0];
		mFlt_d[1] = mFlt_q[1];
		aFlt_d[0] = aFlt_q[0];
		aFlt_d[1] = aFlt_q[1];
		auxOn_d = auxOn_q;
		auxTrip_d = auxTrip_q;
		faultPin_d = faultPin_q;
		pend_d = pend_q;
		pendWr_d = pendWr_q;
		pendAddr_d = pendAddr_q;
		hreadyout_d = hreadyout;
		hrdata_d = hrdata;
		gate_d = 2'b00;
		irqN_d = 1'b1;
		mEn = 1'b0;
		aEn = 1'b0;
		rd = 32'h00000000;
		uv = ~&supOk;

		// Standby qualification window
		if (!stbyOk) begin
			porCnt_d = 32'h00000000;
			porDone_d = 1'b0;
		end else if (!porDone_q) begin
			if (porCnt_q >= POR_CYCLES - 1) porDone_d = 1'b1;
			else porCnt_d = porCnt_q + 32'h00000001;
		end

		// Register read mux
		case (pendAddr_q)
			`OFS_CTRL_A: rd = {30'h00000000, ctrl_q[1:0]};
			`OFS_CTRL_B: rd = {30'h00000000, ctrl_q[3:2]};
			`OFS_STAT_A: rd = {25'h0000000, auxOn_q[0], slotSt_q[1:0], 1'b0, stat_q[2:0]};
			`OFS_STAT_B: rd = {25'h0000000, auxOn_q[1], slotSt_q[3:2], 1'b0, stat_q[5:3]};
			`OFS_COMMON: rd = {22'h000000, ~irqN, standbyMode, stat_q, busCtl_q, intMask_q};
			default: rd = 32'h00000000;
		endcase

		// Data phase, held off until the qualification window ends
		if (pend_q && porDone_q) begin
			pend_d = 1'b0;
			hreadyout_d = 1'b1;
			hrdata_d = pendWr_q ? 32'h00000000 : rd;
			if (pendWr_q) begin
				case (pendAddr_q)
					`OFS_CTRL_A: ctrl_d[1:0] = hwdata[1:0];
					`OFS_CTRL_B: ctrl_d[3:2] = hwdata[1:0];
					`OFS_STAT_A: stat_d[2:0] = stat_q[2:0] & ~hwdata[2:0];
					`OFS_STAT_B: stat_d[5:3] = stat_q[5:3] & ~hwdata[2:0];
					`OFS_COMMON: begin
						intMask_d = hwdata[`CM_MASK];
						busCtl_d = hwdata[`CM_BUSCTL];
						stat_d = stat_q & ~hwdata[`CM_FLT+:6];
					end
					default: begin
					end
				endcase
			end
		end
		// Address phase
		if (hsel && htrans[1] && hready) begin
			pend_d = 1'b1;
			pendWr_d = hwrite;
			pendAddr_d = haddr[7:0];
			hreadyout_d = 1'b0;
		end

		for (i = 0; i < 2; i = i + 1) begin
			mEn = busCtl_q ? ctrl_q[2*i+`CTL_MAIN] : pinMain[i];
			aEn = busCtl_q ? ctrl_q[2*i+`CTL_AUX] : pinAux[i];
			mFlt_d[i] = fltStep(ocMain[i], mFlt_q[i]);
			aFlt_d[i] = fltStep(ocAux[i], aFlt_q[i]);
			case (slotSt_q[2*i+:2])
				`SLOT_OFF: begin
					rampCnt_d[i] = 16'h0000;
					if (mEn && !uv) slotSt_d[2*i+:2] = `SLOT_RAMP;
				end
				`SLOT_RAMP, `SLOT_ON: begin
					if (!mEn) begin
						slotSt_d[2*i+:2] = `SLOT_OFF;
					end else if (fastTrip[i] || mFlt_q[i] >= fltLim(i) || uv) begin
						slotSt_d[2*i+:2] = `SLOT_TRIP;
						if (uv) stat_d[3*i+`ST_UVF] = 1'b1;
						else stat_d[3*i+`ST_MAINF] = 1'b1;
						if (!busCtl_q) faultPin_d[i] = 1'b1;
					end else if (slotSt_q[2*i+:2] == `SLOT_RAMP) begin
						if (rampCnt_q[i] >= `RAMP_CYCLES - 1) slotSt_d[2*i+:2] = `SLOT_ON;
						else rampCnt_d[i] = rampCnt_q[i] + 16'h0001;
					end
				end
				`SLOT_TRIP: begin
					if (!mEn) slotSt_d[2*i+:2] = `SLOT_OFF;
				end
				default: slotSt_d[2*i+:2] = `SLOT_OFF;
			endcase
			// Aux breaker, timer only
			if (auxTrip_q[i]) begin
				auxOn_d[i] = 1'b0;
				if (!aEn) auxTrip_d[i] = 1'b0;
			end else if (auxOn_q[i] && aFlt_q[i] >= fltLim(i)) begin
				auxTrip_d[i] = 1'b1;
				auxOn_d[i] = 1'b0;
				stat_d[3*i+`ST_AUXF] = 1'b1;
				if (!busCtl_q) faultPin_d[i] = 1'b1;
			end else begin
				auxOn_d[i] = aEn;
			end
			if (slotSt_d[2*i+:2] != `SLOT_TRIP && !auxTrip_d[i]) faultPin_d[i] = 1'b0;
		end

		// Power-on reset clears control state and keeps outputs off
		if (!porDone_q) begin
			ctrl_d = 4'h0;
			intMask_d = 1'b0;
			busCtl_d = 1'b0;
			stat_d = 6'h00;
			slotSt_d = {`SLOT_OFF, `SLOT_OFF};
			rampCnt_d[0] = 16'h0000;
			rampCnt_d[1] = 16'h0000;
			mFlt_d[0] = 16'h0000;
			mFlt_d[1] = 16'h0000;
			aFlt_d[0] = 16'h0000;
			aFlt_d[1] = 16'h0000;
			auxOn_d = 2'b00;
			auxTrip_d = 2'b00;
			faultPin_d = 2'b00;
		end

		for (i = 0; i < 2; i = i + 1) begin
			gate_d[i] = slotSt_d[2*i+:2] == `SLOT_RAMP || slotSt_d[2*i+:2] == `SLOT_ON;
		end
		irqN_d = ~((|stat_d) && !intMask_d);
	end

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			syncA_q <= 15'h0000;
			syncB_q <= 15'h0000;
			porCnt_q <= 32'h00000000;
			porDone_q <= 1'b0;
			ctrl_q <= 4'h0;
			intMask_q <= 1'b0;
			busCtl_q <= 1'b0;
			stat_q <= 6'h00;
			slotSt_q <= 4'h0;
			rampCnt_q[0] <= 16'h0000;
			rampCnt_q[1] <= 16'h0000;
			mFlt_q[0] <= 16'h0000;
			mFlt_q[1] <= 16'h0000;
			aFlt_q[0] <= 16'h0000;
			aFlt_q[1] <= 16'h0000;
			auxOn_q <= 2'b00;
			auxTrip_q <= 2'b00;
			faultPin_q <= 2'b00;
			pend_q <= 1'b0;
			pendWr_q <= 1'b0;
			pendAddr_q <= 8'h00;
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
			hresp <= 1'b0;
			mainGateOn <= 2'b00;
			mainDischarge <= 2'b11;
			slotAuxOutput <= 2'b00;
			auxDischarge <= 2'b11;
			slotFaultN <= 2'b11;
			irqN <= 1'b1;
			standbyMode <= 1'b0;
			porActive <= 1'b1;
		end else begin
			syncA_q <= {standbySupplyOk, mainSupplyOk, mainEnablePin, slotAuxEnablePin,
				mainOverCurrent, mainFastTrip, auxOverCurrent};
			syncB_q <= syncA_q;
			porCnt_q <= porCnt_d;
			porDone_q <= porDone_d;
			ctrl_q <= ctrl_d;
			intMask_q <= intMask_d;
			busCtl_q <= busCtl_d;
			stat_q <= stat_d;
			slotSt_q <= slotSt_d;
			rampCnt_q[0] <= rampCnt_d[0];
			rampCnt_q[1] <= rampCnt_d[1];
			mFlt_q[0] <= mFlt_d[0];
			mFlt_q[1] <= mFlt_d[1];
			aFlt_q[0] <= aFlt_d[0];
			aFlt_q[1] <= aFlt_d[1];
			auxOn_q <= auxOn_d;
			auxTrip_q <= auxTrip_d;
			faultPin_q <= faultPin_d;
			pend_q <= pend_d;
			pendWr_q <= pendWr_d;
			pendAddr_q <= pendAddr_d;
			hreadyout <= hreadyout_d;
			hrdata <= hrdata_d;
			hresp <= 1'b0;
			mainGateOn <= gate_d;
			mainDischarge <= ~gate_d;
			slotAuxOutput <= auxOn_d;
			auxDischarge <= ~auxOn_d;
			slotFaultN <= ~faultPin_d;
			irqN <= irqN_d;
			standbyMode <= uv && porDone_q;
			porActive <= ~porDone_d;
		end
	end

endmodule
`default_nettype wire

// ### tb/hotplug_seq_monitor.sv
// Port checker for the hot-plug sequencer
`timescale 1ns/1ns
`default_nettype none
module hotplug_seq_monitor #(
	parameter POR_CYCLES = 20,
	parameter FLT_CYCLES_A = 10,
	parameter FLT_CYCLES_B = 10
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic porActive,
	input wire logic hreadyout,
	input wire logic standbyMode,
	input wire logic [3:0] mainSupplyOk,
	input wire logic [1:0] mainGateOn,
	input wire logic [1:0] mainDischarge,
	input wire logic [1:0] slotAuxOutput,
	input wire logic [1:0] auxDischarge,
	input wire logic [1:0] mainOverCurrent,
	input wire logic [1:0] mainFastTrip,
	input wire logic [1:0] auxOverCurrent
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_por_off: assert property (porActive && $past(porActive) |->
		mainGateOn == 2'h0 && slotAuxOutput == 2'h0) else $error("output on in window");
	a_por_wait: assert property ($rose(hreadyout) |-> !porActive)
		else $error("bus answered in window");
	a_main_dis: assert property (mainDischarge == ~mainGateOn)
		else $error("main discharge wrong");
	a_aux_dis: assert property (auxDischarge == ~slotAuxOutput)
		else $error("aux discharge wrong");
	a_standby_in: assert property ($fell(mainSupplyOk[0]) && !porActive |-> ##[1:5] standbyMode)
		else $error("no standby");
	a_fast_off: assert property ($rose(mainFastTrip[1]) |-> ##[1:5] !mainGateOn[1])
		else $error("fast trip slow");
	a_main_hold: assert property ($rose(mainOverCurrent[0]) && mainGateOn[0] |=>
		mainGateOn[0] [*8]) else $error("main tripped early");
	a_aux_hold: assert property ($rose(auxOverCurrent[0]) && slotAuxOutput[0] |=>
		slotAuxOutput[0] [*8]) else $error("aux tripped early");
	a_aux_kept: assert property ($fell(mainGateOn[0]) && mainOverCurrent[0]
		&& $past(slotAuxOutput[0]) |-> slotAuxOutput[0]) else $error("aux lost");
	cover property ($fell(mainGateOn[0]));
	cover property ($fell(slotAuxOutput[0]));
	cover property ($rose(standbyMode));
endmodule
bind hotplug_power_sequencer hotplug_seq_monitor #(.POR_CYCLES(POR_CYCLES),
	.FLT_CYCLES_A(FLT_CYCLES_A), .FLT_CYCLES_B(FLT_CYCLES_B)) mon (.clk_sys(clk_sys),
	.rstn(rstn), .porActive(porActive), .hreadyout(hreadyout), .standbyMode(standbyMode),
	.mainSupplyOk(mainSupplyOk), .mainGateOn(mainGateOn), .mainDischarge(mainDischarge),
	.slotAuxOutput(slotAuxOutput), .auxDischarge(auxDischarge),
	.mainOverCurrent(mainOverCurrent), .mainFastTrip(mainFastTrip),
	.auxOverCurrent(auxOverCurrent));
`default_nettype wire

// ### tb/hotplug_host_model.sv
// Host-side driver of the slot enable pins
`timescale 1ns/1ns
`default_nettype none
module hotplug_host_model (
	input wire logic busMode,
	input wire logic [1:0] mainReq,
	input wire logic [1:0] auxReq,
	output wire logic [1:0] mainEnablePin,
	output wire logic [1:0] slotAuxEnablePin
);
	assign mainEnablePin = busMode ? 2'h0 : mainReq;
	assign slotAuxEnablePin = busMode ? 2'h0 : auxReq;
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the hot-plug sequencer
`include "hotplug_seq_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk_sys = 1'b0, rstn = 1'b0, sbOk = 1'b1, busMode = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, irqN, stby, por;
	logic [3:0] supOk = 4'hf;
	logic [1:0] mainReq = 2'h0, auxReq = 2'h0, oc = 2'h0, ft = 2'h0, aoc = 2'h0;
	logic [1:0] htrans = 2'h0, mainEn, auxEn, gate, mDis, auxOut, aDis, faultN;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	int nMismatch = 0, nChecks = 0, cyc = 0;
	hotplug_host_model host (.busMode(busMode), .mainReq(mainReq), .auxReq(auxReq),
		.mainEnablePin(mainEn), .slotAuxEnablePin(auxEn));
	hotplug_power_sequencer #(.POR_CYCLES(20), .FLT_CYCLES_A(10), .FLT_CYCLES_B(10)) uut (
		.clk_sys(clk_sys), .rstn(rstn), .standbySupplyOk(sbOk), .mainSupplyOk(supOk),
		.mainEnablePin(mainEn), .slotAuxEnablePin(auxEn), .mainOverCurrent(oc),
		.mainFastTrip(ft), .auxOverCurrent(aoc), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.mainGateOn(gate), .mainDischarge(mDis), .slotAuxOutput(auxOut),
		.auxDischarge(aDis), .slotFaultN(faultN), .irqN(irqN), .standbyMode(stby),
		.porActive(por));
	always #5 clk_sys = ~clk_sys;
	task stopTest;
		$display("checks %0d mismatches %0d", nChecks, nMismatch);
		if (nMismatch == 0 && nChecks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			nMismatch++;
			stopTest;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			nMismatch++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cy(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		rd = hrdata;
	endtask
	task rdc(input logic [31:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		chk(rd, exp);
	endtask
	initial begin
		cy(16);
		rstn <= 1'b1;
		cy(15);
		chk(por, 1'b1);
		chk(gate, 2'h0);
		rdc(`OFS_COMMON, 32'h0);
		chk(por, 1'b0);
		chk(hresp, 1'b0);
		rdc(`OFS_STAT_A, 32'h0);
		rdc(32'h40, 32'h0);
		$display("test window done");
		mainReq <= 2'h1;
		auxReq <= 2'h1;
		cy(110);
		chk(gate, 2'h1);
		chk(mDis, 2'h2);
		chk(auxOut, 2'h1);
		chk(aDis, 2'h2);
		rdc(`OFS_STAT_A, 32'h60);
		oc <= 2'h1;
		cy(16);
		chk(gate, 2'h0);
		chk(auxOut, 2'h1);
		chk(faultN, 2'h2);
		chk(irqN, 1'b0);
		oc <= 2'h0;
		rdc(`OFS_STAT_A, 32'h71);
		mainReq <= 2'h0;
		cy(6);
		chk(faultN, 2'h3);
		rdc(`OFS_STAT_A, 32'h41);
		mainReq <= 2'h3;
		cy(8);
		chk(gate, 2'h3);
		ft <= 2'h2;
		cy(6);
		chk(gate, 2'h1);
		ft <= 2'h0;
		bus(`OFS_STAT_A, 1'b1, 32'h1);
		cy(2);
		chk(irqN, 1'b0);
		rdc(`OFS_COMMON, 32'h220);
		bus(`OFS_COMMON, 1'b1, 32'h20);
		cy(2);
		chk(irqN, 1'b1);
		mainReq <= 2'h0;
		$display("test pin trips done");
		aoc <= 2'h1;
		cy(20);
		chk(auxOut, 2'h0);
		chk(faultN, 2'h2);
		aoc <= 2'h0;
		rdc(`OFS_STAT_A, 32'h2);
		auxReq <= 2'h0;
		cy(6);
		chk(faultN, 2'h3);
		bus(`OFS_STAT_A, 1'b1, 32'h2);
		$display("test aux trip done");
		busMode <= 1'b1;
		bus(`OFS_COMMON, 1'b1, 32'h2);
		bus(`OFS_CTRL_A, 1'b1, 32'h3);
		cy(8);
		chk(gate, 2'h1);
		chk(auxOut, 2'h1);
		supOk <= 4'he;
		cy(8);
		chk(stby, 1'b1);
		chk(gate, 2'h0);
		chk(auxOut, 2'h1);
		chk(faultN, 2'h3);
		chk(irqN, 1'b0);
		rdc(`OFS_STAT_A, 32'h74);
		bus(`OFS_COMMON, 1'b1, 32'h3);
		cy(2);
		chk(irqN, 1'b1);
		supOk <= 4'hf;
		bus(`OFS_CTRL_A, 1'b1, 32'h2);
		bus(`OFS_STAT_A, 1'b1, 32'h4);
		supOk <= 4'he;
		cy(8);
		chk(stby, 1'b1);
		chk(auxOut, 2'h1);
		rdc(`OFS_STAT_A, 32'h40);
		$display("test bus mode done");
		supOk <= 4'hf;
		sbOk <= 1'b0;
		cy(6);
		chk(por, 1'b1);
		chk(auxOut, 2'h0);
		chk(aDis, 2'h3);
		sbOk <= 1'b1;
		rdc(`OFS_CTRL_A, 32'h0);
		rdc(`OFS_COMMON, 32'h0);
		rdc(`OFS_STAT_A, 32'h0);
		$display("test recycle done");
		stopTest;
	end
endmodule
`default_nettype wire
